// file: hdl/i2cc_regs.svh
// Constants and timing counts of the two-wire bus controller.
`ifndef I2CC_REGS_SVH
`define I2CC_REGS_SVH
`define I2CC_CLK_MHZ      25
`define I2CC_STD_QTR_NS   2500
`define I2CC_FAST_QTR_NS  625
`define I2CC_STD_QTR_CYC  ((`I2CC_STD_QTR_NS * `I2CC_CLK_MHZ) / 1000)
`define I2CC_FAST_QTR_CYC ((`I2CC_FAST_QTR_NS * `I2CC_CLK_MHZ) / 1000)
`define I2CC_PREFIX       5'h1E
`define I2CC_ACK_BIT      4'h8
`endif

// file: hdl/i2cc_pkg.sv
// Types of the two-wire bus controller.
package i2cc_pkg;
	typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_HOLD, M_RESTART, M_STOP} i2cc_mst_t;
	typedef enum logic [1:0] {S_IDLE, S_BYTE, S_ACK} i2cc_slv_t;
	typedef enum logic [1:0] {K_FIRST, K_SECOND, K_DATA, K_READ} i2cc_kind_t;
	typedef struct packed {
		logic       sda_s1, sda_s2, sda_d, scl_s1, scl_s2, scl_d;
		i2cc_mst_t  mst;
		logic [1:0] phase;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic       go, restart, stop_req, is_addr, rxdir, mscl_low, msda_low;
		i2cc_slv_t  slv;
		i2cc_kind_t kind;
		logic [3:0] sbit;
		logic [7:0] sshift;
		logic       sel10, ack_drive, stretch;
		logic [7:0] rdata;
		logic       pend, addr_sent, tx_vacant, ack_rx;
	} i2cc_state_t;
	typedef struct packed {
		logic [11:0] cnt;
		logic        tick;
	} i2cc_tick_t;
endpackage

// file: hdl/i2cc_tick_gen.sv
// Quarter-bit tick generator for the bus clock.
`timescale 1ns/1ps
`include "i2cc_regs.svh"
module i2cc_tick_gen import i2cc_pkg::*; #(
	parameter int STD_CYC  = `I2CC_STD_QTR_CYC,
	parameter int FAST_CYC = `I2CC_FAST_QTR_CYC
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_enable,
	input  wire logic [1:0] i_clock_divider_select,
	input  wire logic       i_clock_source_select,
	input  wire logic       i_bus_speed_select,
	output logic            o_qtr_tick
);
	// The largest limit is the base shifted by four, so it must fit in twelve bits.
	if (STD_CYC < 2 || FAST_CYC < 2 || STD_CYC > 255 || FAST_CYC > 255) begin : g_chk
		$error("i2cc_tick_gen: quarter-bit counts out of range");
	end

	i2cc_tick_t  q, n;
	logic [11:0] lim;

	always_comb begin
		lim = ((i_bus_speed_select ? 12'(FAST_CYC) : 12'(STD_CYC))
			<< i_clock_divider_select) << i_clock_source_select;
		n = q;
		n.tick = 1'b0;
		if (!i_enable) begin
			n.cnt = 12'h000;
		end else if (q.cnt >= lim - 12'h001) begin
			n.cnt = 12'h000;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 12'h001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign o_qtr_tick = q.tick;
endmodule

// file: hdl/i2cc_ctrl.sv
// Two-wire bus controller: master transmit/receive and 7/10-bit slave receive.
`timescale 1ns/1ps
`include "i2cc_regs.svh"
module i2cc_ctrl import i2cc_pkg::*; (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [1:0] i_clock_divider_select,
	input  wire logic       i_clock_source_select,
	input  wire logic       i_bus_speed_select,
	input  wire logic       i_bus_enable_bit,
	input  wire logic       i_master_slave_select,
	input  wire logic [7:0] i_target_address_register,
	input  wire logic [7:0] i_data_buffer,
	input  wire logic [7:0] i_own_address_register,
	input  wire logic [1:0] i_own_address_hi,
	input  wire logic       i_strobe,
	input  wire logic       i_stop_request,
	input  wire logic       i_repeat_start,
	input  wire logic       i_pend_clear,
	input  wire logic       i_scl_in,
	input  wire logic       i_sda_in,
	output logic            o_scl_out,
	output logic            o_scl_oe_n,
	output logic            o_sda_out,
	output logic            o_sda_oe_n,
	output logic [7:0]      o_data_buffer,
	output logic            o_pend,
	output logic            o_address_sent_flag,
	output logic            o_tx_vacant,
	output logic            o_ack_received,
	output logic            o_busy,
	output logic            o_selected
);
	i2cc_state_t q, n;
	logic        tick, m_en, s_en, rise, fall, s_start, s_stop;
	logic        s_eval, s_ack, s_load, m_done, pre, own7;

	assign m_en = i_bus_enable_bit & i_master_slave_select;
	assign s_en = i_bus_enable_bit & ~i_master_slave_select;

	i2cc_tick_gen u_tick (
		.i_ref_clk              (i_ref_clk),
		.i_rst                  (i_rst),
		.i_enable               (m_en),
		.i_clock_divider_select (i_clock_divider_select),
		.i_clock_source_select  (i_clock_source_select),
		.i_bus_speed_select     (i_bus_speed_select),
		.o_qtr_tick             (tick)
	);

	assign rise    = q.scl_s2 & ~q.scl_d;
	assign fall    = ~q.scl_s2 & q.scl_d;
	assign s_start = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
	assign s_stop  = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
	assign pre     = (q.sshift[7:3] == `I2CC_PREFIX) && (q.sshift[2:1] == i_own_address_hi);
	assign own7    = q.sshift[7:1] == i_own_address_register[6:0];

	always_comb begin
		n = q;
		s_eval = 1'b0;
		s_ack = 1'b0;
		s_load = 1'b0;
		m_done = 1'b0;
		n.sda_s1 = i_sda_in;
		n.sda_s2 = q.sda_s1;
		n.sda_d = q.sda_s2;
		n.scl_s1 = i_scl_in;
		n.scl_s2 = q.scl_s1;
		n.scl_d = q.scl_s2;
		// Clears come first so that a hardware set in the same cycle wins.
		if (i_strobe) begin
			n.go = 1'b1;
			n.stop_req = i_stop_request;
			n.restart = i_repeat_start;
			n.addr_sent = 1'b0;
			n.tx_vacant = 1'b0;
		end
		if (i_pend_clear) begin
			n.pend = 1'b0;
		end
		if (!m_en) begin
			n.mst = M_IDLE;
			n.mscl_low = 1'b0;
			n.msda_low = 1'b0;
			n.go = 1'b0;
		end else if (tick) begin
			n.phase = q.phase + 2'h1;
			unique case (q.mst)
				M_IDLE: begin
					n.phase = 2'h0;
					if (q.go) begin
						n.go = 1'b0;
						n.mst = M_START;
						n.shift = i_target_address_register;
						n.is_addr = 1'b1;
						n.rxdir = 1'b0;
					end
				end
				M_START: begin
					if (q.phase == 2'h0) begin
						n.msda_low = 1'b1;
					end else begin
						n.mscl_low = 1'b1;
						n.mst = M_BITS;
						n.phase = 2'h0;
						n.bitn = 4'h0;
					end
				end
				M_BITS: begin
					unique case (q.phase)
						2'h0: n.msda_low = (q.bitn == `I2CC_ACK_BIT) ? (q.rxdir & ~q.stop_req)
							: (~q.rxdir & ~q.shift[7]);
						2'h1: n.mscl_low = 1'b0;
						2'h2: begin
							if (q.bitn == `I2CC_ACK_BIT) begin
								n.ack_rx = ~q.sda_s2;
							end else begin
								n.shift = {q.shift[6:0], q.sda_s2};
							end
						end
						2'h3: begin
							n.mscl_low = 1'b1;
							n.bitn = q.bitn + 4'h1;
							if (q.bitn == `I2CC_ACK_BIT) begin
								m_done = 1'b1;
								n.bitn = 4'h0;
								n.is_addr = 1'b0;
								if (q.is_addr) begin
									n.addr_sent = 1'b1;
									n.rxdir = q.shift[0];
								end else if (q.rxdir) begin
									n.rdata = q.shift;
									n.pend = 1'b1;
								end else begin
									n.tx_vacant = 1'b1;
								end
								n.mst = q.stop_req ? M_STOP : M_HOLD;
							end
						end
					endcase
				end
				M_HOLD: begin
					n.phase = 2'h0;
					if (q.go) begin
						n.go = 1'b0;
						if (q.restart) begin
							n.mst = M_RESTART;
							n.shift = i_target_address_register;
							n.is_addr = 1'b1;
							n.rxdir = 1'b0;
						end else begin
							n.mst = M_BITS;
							n.shift = i_data_buffer;
						end
					end
				end
				M_RESTART: begin
					if (q.phase == 2'h0) begin
						n.msda_low = 1'b0;
					end else if (q.phase == 2'h1) begin
						n.mscl_low = 1'b0;
					end else begin
						n.mst = M_START;
						n.phase = 2'h0;
					end
				end
				M_STOP: begin
					unique case (q.phase)
						2'h0: begin
							n.mscl_low = 1'b1;
							n.msda_low = 1'b1;
						end
						2'h1: n.mscl_low = 1'b0;
						2'h2: n.msda_low = 1'b0;
						2'h3: begin
							n.mst = M_IDLE;
							n.stop_req = 1'b0;
						end
					endcase
				end
			endcase
		end
		if (q.stretch && !n.pend) begin
			n.stretch = 1'b0;
		end
		if (!s_en) begin
			n.slv = S_IDLE;
			n.sel10 = 1'b0;
			n.ack_drive = 1'b0;
			n.stretch = 1'b0;
		end else if (s_stop) begin
			n.slv = S_IDLE;
			n.sel10 = 1'b0;
			n.ack_drive = 1'b0;
		end else if (s_start) begin
			// A repeated start keeps the 10-bit selection for a following read.
			n.slv = S_BYTE;
			n.sbit = 4'h0;
			n.kind = K_FIRST;
			n.ack_drive = 1'b0;
		end else begin
			unique case (q.slv)
				S_IDLE: ;
				S_BYTE: begin
					if (rise) begin
						n.sshift = {q.sshift[6:0], q.sda_s2};
						n.sbit = q.sbit + 4'h1;
					end else if (fall && q.sbit == `I2CC_ACK_BIT) begin
						s_eval = 1'b1;
						unique case (q.kind)
							K_FIRST: begin
								if (pre && !q.sshift[0]) begin
									s_ack = 1'b1;
									n.kind = K_SECOND;
									n.sel10 = 1'b0;
								end else if (pre) begin
									s_ack = q.sel10;
									n.kind = K_READ;
								end else begin
									n.sel10 = 1'b0;
									if (own7) begin
										s_ack = 1'b1;
										s_load = ~q.sshift[0];
										n.kind = q.sshift[0] ? K_READ : K_DATA;
									end
								end
							end
							K_SECOND: begin
								if (q.sshift == i_own_address_register) begin
									s_ack = 1'b1;
									s_load = 1'b1;
									n.sel10 = 1'b1;
									n.kind = K_DATA;
								end
							end
							K_DATA: begin
								s_ack = 1'b1;
								s_load = 1'b1;
							end
							K_READ: ;
						endcase
						n.ack_drive = s_ack;
						n.slv = s_ack ? S_ACK : S_IDLE;
						n.sbit = 4'h0;
						if (s_load) begin
							n.rdata = q.sshift;
							n.pend = 1'b1;
						end
					end
				end
				S_ACK: begin
					if (fall) begin
						n.ack_drive = 1'b0;
						n.stretch = n.pend;
						// Slave transmit is not served; a read ends the slave's part.
						n.slv = (q.kind == K_READ) ? S_IDLE : S_BYTE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign o_scl_out           = 1'b0;
	assign o_sda_out           = 1'b0;
	assign o_scl_oe_n          = ~(q.mscl_low | q.stretch);
	assign o_sda_oe_n          = ~(q.msda_low | q.ack_drive);
	assign o_data_buffer       = q.rdata;
	assign o_pend              = q.pend;
	assign o_address_sent_flag = q.addr_sent;
	assign o_tx_vacant         = q.tx_vacant;
	assign o_ack_received      = q.ack_rx;
	assign o_busy              = q.mst != M_IDLE;
	assign o_selected          = q.sel10;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_first_ack;
		s_eval && q.kind == K_FIRST && pre && !q.sshift[0] |=> !o_sda_oe_n && q.kind == K_SECOND;
	endproperty
	a_first_ack: assert property (p_first_ack) else $error("prefix write not acknowledged");
	property p_second;
		s_eval && q.kind == K_SECOND && q.sshift != i_own_address_register |=> o_sda_oe_n && !q.sel10;
	endproperty
	a_second: assert property (p_second) else $error("wrong low address acknowledged");
	property p_stop_desel;
		s_en && s_stop |=> !o_selected;
	endproperty
	a_stop_desel: assert property (p_stop_desel) else $error("selection kept after stop");
	property p_read_prefix;
		s_eval && q.kind == K_FIRST && pre && q.sshift[0] |=> o_sda_oe_n == !$past(q.sel10);
	endproperty
	a_read_prefix: assert property (p_read_prefix) else $error("read prefix ack wrong");
	property p_addr_sent;
		m_done && q.is_addr |=> o_address_sent_flag && !o_scl_oe_n;
	endproperty
	a_addr_sent: assert property (p_addr_sent) else $error("address-sent flag missing");
	property p_vacant;
		m_done && !q.is_addr && !q.rxdir |=> o_tx_vacant;
	endproperty
	a_vacant: assert property (p_vacant) else $error("transmit-vacant flag missing");
	property p_stop_gen;
		m_en && tick && q.mst == M_STOP && q.phase == 2'h2
			|=> o_sda_oe_n && o_scl_oe_n && q.mst == M_STOP;
	endproperty
	a_stop_gen: assert property (p_stop_gen) else $error("stop condition not released");
	property p_load;
		s_en && s_load && !s_start && !s_stop |=> o_pend && o_data_buffer == $past(q.sshift);
	endproperty
	a_load: assert property (p_load) else $error("received byte not loaded");
	property p_stretch;
		q.stretch |-> !o_scl_oe_n && o_pend;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not held while pending");
	property p_disabled;
		!i_bus_enable_bit |=> o_scl_oe_n && o_sda_oe_n;
	endproperty
	a_disabled: assert property (p_disabled) else $error("bus driven while disabled");

	c_sel10: cover property ($rose(q.sel10));
	c_read_ack: cover property (s_eval && q.kind == K_FIRST && pre && q.sshift[0] && q.sel10);
	c_stretch: cover property ($rose(q.stretch));
	c_master_stop: cover property (q.mst == M_STOP ##1 q.mst == M_IDLE);
endmodule

// file: sim/i2cc_far_model.sv
// Far-side bus party: a listening target and an addressing initiator.
`timescale 1ns/1ps
module i2cc_far_model (
	input  wire logic i_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_rel,
	output logic      o_sda_rel
);
	logic       act = 1'b0;
	logic       scl_d = 1'b1;
	logic       sda_d = 1'b1;
	logic [7:0] sh;
	int         bits = 0;
	int         stops = 0;
	int         per = 0;
	int         cnt = 0;
	int         hung = 0;
	logic [7:0] rx_q[$];
	initial begin
		o_scl_rel = 1'b1;
		o_sda_rel = 1'b1;
	end
	// The target acknowledges every byte and never sends data back.
	always @(posedge i_clk) begin
		scl_d <= i_scl;
		sda_d <= i_sda;
		cnt <= (i_scl && !scl_d) ? 1 : cnt + 1;
		if (i_scl && !scl_d)
			per <= cnt;
		if (act && i_scl && scl_d && sda_d && !i_sda)
			bits <= 0;
		else if (act && i_scl && scl_d && !sda_d && i_sda)
			stops <= stops + 1;
		else if (act && i_scl && !scl_d) begin
			sh <= {sh[6:0], i_sda};
			bits <= bits + 1;
		end else if (act && !i_scl && scl_d && bits == 8) begin
			rx_q.push_back(sh);
			o_sda_rel <= 1'b0;
		end else if (act && !i_scl && scl_d && bits == 9) begin
			bits <= 0;
			o_sda_rel <= 1'b1;
		end
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// The device may stretch the clock, so every release waits for the line to rise.
	task automatic hi();
		int k;
		for (k = 0; k < 4000 && !i_scl; k++)
			@(negedge i_clk);
		if (!i_scl)
			hung++;
	endtask
	task automatic bit_out(input logic b);
		o_sda_rel = b;
		wt(20);
		o_scl_rel = 1'b1;
		hi();
		wt(20);
		o_scl_rel = 1'b0;
		wt(8);
	endtask
	// Serves as start and repeated start; any address format may follow.
	task automatic start_c();
		o_sda_rel = 1'b1;
		wt(20);
		o_scl_rel = 1'b1;
		hi();
		wt(20);
		o_sda_rel = 1'b0;
		wt(20);
		o_scl_rel = 1'b0;
		wt(8);
	endtask
	// Sends MSB first; the direction bit of an address byte goes last.
	task automatic put(input logic [7:0] b, output logic a);
		int i;
		for (i = 7; i >= 0; i--)
			bit_out(b[i]);
		o_sda_rel = 1'b1;
		wt(20);
		o_scl_rel = 1'b1;
		hi();
		a = !i_sda;
		wt(20);
		o_scl_rel = 1'b0;
		wt(8);
	endtask
	task automatic stop_c();
		o_sda_rel = 1'b0;
		wt(20);
		o_scl_rel = 1'b1;
		hi();
		wt(20);
		o_sda_rel = 1'b1;
		wt(20);
	endtask
endmodule

// file: sim/i2c_ten_bit_addr_controller_bench.sv
// Self-checking bench of the two-wire controller against the far-side model.
`timescale 1ns/1ps
module i2c_ten_bit_addr_controller_bench;
	import i2cc_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] div = 2'h0;
	logic       src = 1'b0;
	logic       spd = 1'b1;
	logic       en = 1'b0;
	logic       ms = 1'b1;
	logic [7:0] tgt = 8'h00;
	logic [7:0] dbuf = 8'h00;
	logic [7:0] olo = 8'h00;
	logic [1:0] ohi = 2'h0;
	logic       stb = 1'b0;
	logic       stopr = 1'b0;
	logic       rs = 1'b0;
	logic       pclr = 1'b0;
	logic       scl_oe_n, sda_oe_n, m_scl, m_sda, pend, asent, txv, ackr, busy, sel;
	logic       scl_o, sda_o;
	logic [7:0] rx, lo, d;
	wire        scl = scl_oe_n & m_scl;
	wire        sda = sda_oe_n & m_sda;
	int         err_count = 0;
	int         checks_done = 0;
	int         rsel = 0;
	int         rpf = 0;
	int         q, st;
	i2cc_ctrl dut_u (.i_ref_clk(clk), .i_rst(rst), .i_clock_divider_select(div),
		.i_clock_source_select(src), .i_bus_speed_select(spd), .i_bus_enable_bit(en),
		.i_master_slave_select(ms), .i_target_address_register(tgt), .i_data_buffer(dbuf),
		.i_own_address_register(olo), .i_own_address_hi(ohi), .i_strobe(stb),
		.i_stop_request(stopr), .i_repeat_start(rs), .i_pend_clear(pclr), .i_scl_in(scl),
		.i_sda_in(sda), .o_scl_out(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda_out(sda_o),
		.o_sda_oe_n(sda_oe_n), .o_data_buffer(rx), .o_pend(pend), .o_address_sent_flag(asent),
		.o_tx_vacant(txv), .o_ack_received(ackr), .o_busy(busy), .o_selected(sel));
	i2cc_far_model far (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_rel(m_scl),
		.o_sda_rel(m_sda));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t bit %b expected %b", $time, g, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_on(input int w);
		int k;
		for (k = 0; k < 20000; k++) begin
			@(negedge clk);
			if ((w == 0 && asent === 1'b1) || (w == 1 && txv === 1'b1)
				|| (w == 2 && busy === 1'b0))
				break;
		end
		if (k == 20000) begin
			err_count++;
			$display("BAD %0t wait expired", $time);
			end_sim();
		end
	endtask
	task automatic strobe_t(input logic [7:0] b, input logic s);
		dbuf = b;
		stopr = s;
		stb = 1'b1;
		@(negedge clk);
		stb = 1'b0;
		stopr = 1'b0;
	endtask
	// Reference: decides acknowledge and load from the own address and selection state.
	task automatic sx(input logic [7:0] b, input int pos);
		int  bi;
		bit  ea, el;
		logic ak;
		bi = b;
		el = 1'b0;
		if (pos == 0 && bi / 8 == 30 && bi % 2 == 1)
			ea = bi / 2 % 4 == ohi && rsel != 0;
		else if (pos == 0 && bi / 8 == 30) begin
			rpf = bi / 2 % 4 == ohi;
			rsel = 0;
			ea = rpf != 0;
		end else if (pos == 0) begin
			rsel = 0;
			ea = bi / 2 == olo % 128;
			el = ea;
		end else if (pos == 1) begin
			rsel = rpf != 0 && b == olo;
			ea = rsel != 0;
			el = ea;
		end else begin
			ea = 1'b1;
			el = 1'b1;
		end
		far.put(b, ak);
		chkb(ak, ea);
		if (el) begin
			chk(rx, b);
			chkb(pend, 1'b1);
			chkb(scl_oe_n, 1'b0);
			pclr = 1'b1;
			@(negedge clk);
			pclr = 1'b0;
			repeat (4) @(negedge clk);
			chkb(pend, 1'b0);
			chkb(scl_oe_n, 1'b1);
		end
	endtask
	initial begin
		void'($urandom(32'hE37B40A9));
		repeat (16) @(negedge clk);
		rst = 1'b0;
		en = 1'b1;
		far.act = 1'b1;
		for (int k = 0; k < 3; k++) begin
			spd = (k != 2);
			div = 2'(k == 1);
			src = (k == 1);
			q = (spd ? 15 : 62) << div << src;
			tgt = {5'h1E, 2'($urandom), 1'b0};
			lo = 8'($urandom);
			d = 8'($urandom);
			far.rx_q.delete();
			st = far.stops;
			strobe_t(8'h00, 1'b0);
			wait_on(0);
			chkb(ackr, 1'b1);
			strobe_t(lo, 1'b0);
			wait_on(1);
			strobe_t(d, 1'b1);
			wait_on(2);
			chk(far.rx_q[0], tgt);
			chk(far.rx_q[1], lo);
			chk(far.rx_q[2], d);
			chk(8'(far.stops - st), 8'h01);
			chk(8'(far.per), 8'(4 * q));
		end
		// Combined format as master: prefix and low byte, then a repeated start and a read.
		tgt = {5'h1E, 2'($urandom), 1'b0};
		far.rx_q.delete();
		strobe_t(8'h00, 1'b0);
		wait_on(0);
		strobe_t(8'($urandom), 1'b0);
		wait_on(1);
		tgt[0] = 1'b1;
		rs = 1'b1;
		strobe_t(8'h00, 1'b0);
		rs = 1'b0;
		wait_on(0);
		chk(far.rx_q[2], tgt);
		strobe_t(8'h00, 1'b1);
		wait_on(2);
		chk(rx, 8'hFF);
		chkb(pend, 1'b1);
		pclr = 1'b1;
		@(negedge clk);
		pclr = 1'b0;
		chkb(pend, 1'b0);
		en = 1'b0;
		strobe_t(8'h00, 1'b1);
		repeat (200) @(negedge clk);
		chkb(busy, 1'b0);
		en = 1'b1;
		ms = 1'b0;
		far.act = 1'b0;
		ohi = 2'($urandom);
		// Bit six stays clear so the 7-bit own address never looks like a 10-bit prefix.
		olo = {2'b00, 6'($urandom)};
		// Write, then read from the same slave after a repeated start.
		far.start_c();
		sx({5'h1E, ohi, 1'b0}, 0);
		sx(olo, 1);
		chkb(sel, 1'b1);
		repeat (2) sx(8'($urandom), 2);
		far.start_c();
		sx({5'h1E, ohi, 1'b1}, 0);
		far.stop_c();
		rsel = 0;
		chkb(sel, 1'b0);
		// A second slave address ends the selection; the read prefix then goes unanswered.
		far.start_c();
		sx({5'h1E, ohi, 1'b0}, 0);
		sx(olo, 1);
		far.start_c();
		sx({5'h1E, ohi, 1'b0}, 0);
		sx(olo ^ 8'h01, 1);
		chkb(sel, 1'b0);
		far.start_c();
		sx({5'h1E, ohi, 1'b1}, 0);
		far.stop_c();
		rsel = 0;
		far.start_c();
		sx({5'h1E, ~ohi, 1'b0}, 0);
		far.start_c();
		sx({olo[6:0], 1'b0}, 0);
		sx(8'($urandom), 2);
		far.stop_c();
		chk(8'(far.hung), 8'h00);
		chkb(scl_o | sda_o, 1'b0);
		end_sim();
	end
endmodule
